// ==== src/pmct_core_timing.sv ====
// instruction issue and retire timing, external-move routing, debug
`timescale 1ns/1ps
// How it works
// RULE_01: most instructions issue and retire within one or two clocks.
// RULE_02: no instruction is held for more than eight clocks.
// RULE_03: the sequencer runs from any clock up to 25 MHz, one per clock.
// RULE_04: the timing table covers 109 codes, 26 at one and 50 at two.
// RULE_05: opcodes keep their standard encoding; only timing is set here.
// RULE_06: every count is in single system clocks, no machine cycles.
// RULE_07: by default an instruction takes as many clocks as its bytes.
// RULE_08: a conditional branch not taken retires one clock earlier.
// RULE_09: the external move goes to on-chip RAM, off-chip RAM or flash.
// RULE_10: flash is read by the code move and written by the external move.
// RULE_11: a serial scan port lets a host program flash and drive debug.
// RULE_12: breakpoints, watchpoints, halt, run, step and memory access.
// RULE_13: debug uses its own memory port and no user resource.
// RULE_14: internal RAM is 256 bytes and the function space 128 bytes.
// RULE_15: the pointer-based external move is one byte and three clocks.
// RULE_16: reset drops the instruction in flight and fetches from zero.
module pmct_core_timing
  import pmct_pkg::*;
(
  input  wire logic          i_clk_sys,
  input  wire logic          i_rstn,
  input  wire logic          i_op_valid,
  input  wire logic [7:0]    i_opcode,
  input  wire logic          i_branch_taken,
  input  wire logic          i_pc_load,
  input  wire logic [15:0]   i_pc_target,
  input  wire logic [15:0]   i_xmove_addr,
  input  wire logic          i_xmove_wr,
  input  wire logic [7:0]    i_xmove_data,
  input  wire logic          i_flash_wr_en,
  input  wire logic [7:0]    i_dbg_rdata,
  input  wire logic          i_dbg_ack,
  input  wire logic          i_jtag_tck,
  input  wire logic          i_jtag_tms,
  input  wire logic          i_jtag_tdi,
  output logic [15:0]        o_fetch_pc,
  output logic               o_issue,
  output logic               o_retire,
  output logic               o_busy,
  output logic               o_xmove_valid,
  output pmct_xmove_type     o_xmove,
  output logic               o_cmove_rd,
  output logic               o_halted,
  output logic               o_dbg_req,
  output logic               o_dbg_wr,
  output logic               o_dbg_flash,
  output logic [15:0]        o_dbg_addr,
  output logic [7:0]         o_dbg_wdata,
  output logic               o_jtag_tdo
);

  // ----------------------------------------------------------------
  // opcode timing table
  // ----------------------------------------------------------------
  function automatic pmct_timing_type timing_of(input logic [7:0] op);
    pmct_timing_type t;
    t = '{bytes: 2'd1, clocks: 4'h1, cond_br: 1'b0, xmove: 1'b0,
          cmove: 1'b0};
    if (op[3]) begin
      t.bytes = 2'd1;
    end else if (op[3:1] == 3'b011) begin
      t.bytes  = 2'd1;
      t.clocks = 4'h2;
    end else if (op[3:0] == 4'h4 || op[3:0] == 4'h5) begin
      t.bytes  = 2'd2;
      t.clocks = 4'h2;
    end
    if (op[3:0] == 4'h1) begin
      t.bytes  = 2'd2;
      t.clocks = PMCT_AJMP_CLKS;
    end
    if (op == 8'ha4 || op == 8'h84) t.bytes = 2'd1;
    case (op)
      8'h02, 8'h12: begin
        t.bytes  = 2'd3;
        t.clocks = PMCT_LJMP_CLKS;
      end
      8'h22, 8'h32: t.clocks = PMCT_RET_CLKS;
      8'h80, 8'h73: t.clocks = {2'b00, t.bytes} + 4'h1;
      8'h10, 8'h20, 8'h30, 8'hd5, 8'hb4, 8'hb5,
      8'hb6, 8'hb7, 8'hb8, 8'hb9, 8'hba, 8'hbb,
      8'hbc, 8'hbd, 8'hbe, 8'hbf: begin
        t.bytes   = 2'd3;
        t.clocks  = 4'h4;
        t.cond_br = 1'b1;
      end
      8'h40, 8'h50, 8'h60, 8'h70, 8'hd8, 8'hd9,
      8'hda, 8'hdb, 8'hdc, 8'hdd, 8'hde, 8'hdf: begin
        t.bytes   = 2'd2;
        t.clocks  = 4'h3;
        t.cond_br = 1'b1;
      end
      8'h83, 8'h93: begin
        t.clocks = PMCT_CMOVE_CLKS;
        t.cmove  = 1'b1;
      end
      8'he0, 8'he2, 8'he3, 8'hf0, 8'hf2, 8'hf3: begin
        t.bytes  = 2'd1;
        t.clocks = PMCT_XMOVE_CLKS;
        t.xmove  = 1'b1;
      end
      8'ha4:   t.clocks = PMCT_MUL_CLKS;
      8'h84:   t.clocks = PMCT_DIV_CLKS;
      default: t.clocks = t.clocks;
    endcase
    if (!t.cond_br && op[3:0] != 4'h1 && t.clocks < {2'b00, t.bytes}) begin
      t.clocks = {2'b00, t.bytes};
    end
    return t;
  endfunction

  function automatic pmct_target_type route_of(input logic [15:0] a,
                                               input logic wr,
                                               input logic fl_en);
    if (wr && fl_en) return PMCT_TGT_FLASH;
    else if (a < PMCT_EXPANSION_RAM_TOP) return PMCT_TGT_EXPANSION_RAM_ON;
    else return PMCT_TGT_EXPANSION_RAM_OFF;
  endfunction

  // ----------------------------------------------------------------
  // issue and retire sequencer
  // ----------------------------------------------------------------
  pmct_timing_type dec;
  pmct_timing_type cur_q;
  logic            active_q;
  logic [3:0]      cyc_q;
  logic [3:0]      need;
  logic [15:0]     pc_q;
  logic            accept;
  logic            bp_hit;
  logic            halt_q, step_q, skip_q;
  logic            bp_en_q, wp_en_q, wp_pend_q;
  logic [15:0]     bp_q, wp_q;
  logic            dbg_valid;
  pmct_dbg_type    dbg_cmd;

  assign dec    = timing_of(i_opcode);                       // see RULE_05
  assign need   = cur_q.clocks -                             // see RULE_08
                  {3'h0, cur_q.cond_br && !i_branch_taken};
  assign o_retire = active_q && cyc_q == need;               // see RULE_06
  assign bp_hit = bp_en_q && pc_q == bp_q && !skip_q;
  assign accept = i_op_valid && !halt_q && !bp_hit &&
                  (!active_q || o_retire);                   // see RULE_01
  assign o_issue    = accept;
  assign o_busy     = active_q;
  assign o_fetch_pc = pc_q;
  assign o_halted   = halt_q;

  // reset flushes work in flight
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      active_q <= 1'b0;                                      // see RULE_16
      cyc_q    <= 4'h0;
      cur_q    <= '0;
    end else if (accept) begin
      active_q <= 1'b1;
      cyc_q    <= 4'h1;                                      // see RULE_03
      cur_q    <= dec;                                       // see RULE_04
    end else if (o_retire) begin
      active_q <= 1'b0;
    end else if (active_q && cyc_q < PMCT_DIV_CLKS) begin
      cyc_q <= cyc_q + 4'h1;                                 // see RULE_02
    end
  end

  // program counter: advance by the bytes of each issued opcode
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      pc_q <= PMCT_RESET_PC;                                 // see RULE_16
    end else if (dbg_valid && dbg_cmd.cmd == PMCT_CMD_PC && halt_q) begin
      pc_q <= dbg_cmd.addr;
    end else if (i_pc_load) begin
      pc_q <= i_pc_target;
    end else if (accept) begin
      pc_q <= pc_q + {14'h0000, dec.bytes};                  // see RULE_07
    end
  end

  // ----------------------------------------------------------------
  // external move routing and code move flash reads
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      o_xmove_valid <= 1'b0;
      o_xmove       <= '0;
      o_cmove_rd    <= 1'b0;
    end else begin
      o_xmove_valid <= accept && dec.xmove;                  // see RULE_15
      o_cmove_rd    <= accept && dec.cmove;                  // see RULE_10
      if (accept && dec.xmove) begin
        o_xmove.target <= route_of(i_xmove_addr, i_xmove_wr,
                                   i_flash_wr_en);           // see RULE_09
        o_xmove.addr   <= i_xmove_addr;
        o_xmove.wr     <= i_xmove_wr;
        o_xmove.data   <= i_xmove_data;
      end
    end
  end

  // ----------------------------------------------------------------
  // debug control
  // ----------------------------------------------------------------
  pmct_debug_port pmct_debug_port_inst (
    .i_clk_sys   (i_clk_sys),
    .i_rstn      (i_rstn),
    .i_jtag_tck  (i_jtag_tck),
    .i_jtag_tms  (i_jtag_tms),
    .i_jtag_tdi  (i_jtag_tdi),
    .i_resp      (o_dbg_wdata),
    .o_jtag_tdo  (o_jtag_tdo),
    .o_cmd_valid (dbg_valid),
    .o_cmd       (dbg_cmd)
  );                                                         // see RULE_11

  // halt on command, breakpoint, watchpoint or one clock after a single-stepped opcode issues
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      halt_q <= 1'b0;
      step_q <= 1'b0;
      skip_q <= 1'b0;
    end else begin
      if (dbg_valid && dbg_cmd.cmd == PMCT_CMD_HALT) begin
        halt_q <= 1'b1;
      end else if (dbg_valid && dbg_cmd.cmd == PMCT_CMD_RUN) begin
        halt_q <= 1'b0;
        skip_q <= 1'b1;
      end else if (dbg_valid && dbg_cmd.cmd == PMCT_CMD_STEP) begin
        halt_q <= 1'b0;
        step_q <= 1'b1;
        skip_q <= 1'b1;
      end else if (bp_hit && !active_q) begin
        halt_q <= 1'b1;                                      // see RULE_12
      end else if (wp_pend_q && !active_q) begin
        halt_q <= 1'b1;
      end else if (accept && step_q) begin
        halt_q <= 1'b1;
        step_q <= 1'b0;
      end
      if (accept) skip_q <= 1'b0;
    end
  end

  // breakpoint and watchpoint comparators, programmed over the port
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      bp_en_q   <= 1'b0;
      wp_en_q   <= 1'b0;
      bp_q      <= 16'h0000;
      wp_q      <= 16'h0000;
      wp_pend_q <= 1'b0;
    end else begin
      if (dbg_valid && dbg_cmd.cmd == PMCT_CMD_BRK) begin
        bp_q    <= dbg_cmd.addr;
        bp_en_q <= dbg_cmd.data[0];
      end
      if (dbg_valid && dbg_cmd.cmd == PMCT_CMD_WATCH) begin
        wp_q    <= dbg_cmd.addr;
        wp_en_q <= dbg_cmd.data[0];
      end
      if (accept && dec.xmove && wp_en_q && i_xmove_addr == wp_q) begin
        wp_pend_q <= 1'b1;
      end else if (halt_q) begin
        wp_pend_q <= 1'b0;
      end
    end
  end

  // private memory port for debug access, only while halted
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      o_dbg_req   <= 1'b0;
      o_dbg_wr    <= 1'b0;
      o_dbg_flash <= 1'b0;
      o_dbg_addr  <= 16'h0000;
      o_dbg_wdata <= 8'h00;
    end else if (dbg_valid && halt_q &&
                 (dbg_cmd.cmd == PMCT_CMD_MRD ||
                  dbg_cmd.cmd == PMCT_CMD_MWR ||
                  dbg_cmd.cmd == PMCT_CMD_FWR)) begin
      o_dbg_req   <= 1'b1;                                   // see RULE_13
      o_dbg_wr    <= dbg_cmd.cmd != PMCT_CMD_MRD;
      o_dbg_flash <= dbg_cmd.cmd == PMCT_CMD_FWR;
      o_dbg_addr  <= dbg_cmd.addr;
      o_dbg_wdata <= dbg_cmd.data;
    end else if (o_dbg_req && i_dbg_ack) begin
      o_dbg_req <= 1'b0;
      if (!o_dbg_wr) o_dbg_wdata <= i_dbg_rdata;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  max_cycles_a: assert property ( // see RULE_02
    @(posedge i_clk_sys) disable iff (!i_rstn)
    o_issue |-> ##[1:8] o_retire)
    else $error("instruction held beyond eight clocks");
  reset_pc_a: assert property ( // see RULE_16
    @(posedge i_clk_sys) disable iff (!i_rstn)
    !$past(i_rstn) |-> o_fetch_pc == 16'h0000 && !o_busy)
    else $error("fetch did not restart at zero");
  one_clk_a: assert property ( // see RULE_01
    @(posedge i_clk_sys) disable iff (!i_rstn)
    o_issue && dec.clocks == 4'h1 |=> o_retire)
    else $error("single clock op not retired next cycle");
  xmove_three_a: assert property ( // see RULE_15
    @(posedge i_clk_sys) disable iff (!i_rstn)
    o_issue && dec.xmove |=> !o_retire ##1 !o_retire ##1 o_retire)
    else $error("external move not three clocks");
  branch_len_a: assert property ( // see RULE_08
    @(posedge i_clk_sys) disable iff (!i_rstn)
    o_retire && cur_q.cond_br |->
      cyc_q == {2'b00, cur_q.bytes} + {3'h0, i_branch_taken})
    else $error("branch length wrong");
  bytes_len_a: assert property ( // see RULE_07
    @(posedge i_clk_sys) disable iff (!i_rstn)
    o_issue && dec.bytes == 2'd2 && !dec.cond_br && i_opcode[3:0] != 4'h1
      |-> dec.clocks >= 4'h2)
    else $error("clocks shorter than bytes");
  halt_still_a: assert property ( // see RULE_12
    @(posedge i_clk_sys) disable iff (!i_rstn)
    o_halted |-> !o_issue)
    else $error("issue while halted");
  flash_route_a: assert property ( // see RULE_10
    @(posedge i_clk_sys) disable iff (!i_rstn)
    o_xmove_valid && o_xmove.target == PMCT_TGT_FLASH |-> o_xmove.wr)
    else $error("flash read routed by external move");
  dbg_quiet_a: assert property ( // see RULE_13
    @(posedge i_clk_sys) disable iff (!i_rstn)
    $rose(o_dbg_req) |-> o_halted && !o_busy)
    else $error("debug access while running");

endmodule

// ==== inc/pmct_pkg.sv ====
// shared constants and carrier types for the core timing controller
package pmct_pkg;

  // ----------------------------------------------------------------
  // clocking and sizes
  // ----------------------------------------------------------------
  localparam int unsigned PMCT_CLK_HZ      = 10_000_000;
  localparam int unsigned PMCT_FMAX_MHZ    = 25;
  localparam int unsigned PMCT_PEAK_MIPS   = 25;
  localparam int unsigned PMCT_MAX_CLOCKS  = 8;
  localparam int unsigned PMCT_IRAM_BYTES  = 256;
  localparam int unsigned PMCT_SFR_BYTES   = 128;
  localparam int unsigned PMCT_INSTR_COUNT = 109;
  localparam logic [15:0] PMCT_RESET_PC    = 16'h0000;
  localparam logic [15:0] PMCT_EXPANSION_RAM_TOP    = 16'h1000;
  localparam logic [3:0]  PMCT_XMOVE_CLKS  = 4'h3;
  localparam logic [3:0]  PMCT_CMOVE_CLKS  = 4'h3;
  localparam logic [3:0]  PMCT_MUL_CLKS    = 4'h4;
  localparam logic [3:0]  PMCT_DIV_CLKS    = 4'h8;
  localparam logic [3:0]  PMCT_RET_CLKS    = 4'h5;
  localparam logic [3:0]  PMCT_LJMP_CLKS   = 4'h4;
  localparam logic [3:0]  PMCT_AJMP_CLKS   = 4'h3;

  // ----------------------------------------------------------------
  // debug scan register layout
  // ----------------------------------------------------------------
  localparam int unsigned PMCT_DR_BITS  = 32;
  localparam int unsigned PMCT_DR_CMD   = 28;
  localparam int unsigned PMCT_DR_ADDR  = 8;
  localparam int unsigned PMCT_DR_DATA  = 0;
  localparam logic [4:0]  PMCT_TLR_TMS  = 5'h05;

  typedef enum logic [3:0] {
    PMCT_CMD_NOP   = 4'h0,
    PMCT_CMD_HALT  = 4'h1,
    PMCT_CMD_RUN   = 4'h2,
    PMCT_CMD_STEP  = 4'h3,
    PMCT_CMD_BRK   = 4'h4,
    PMCT_CMD_WATCH = 4'h5,
    PMCT_CMD_MRD   = 4'h6,
    PMCT_CMD_MWR   = 4'h7,
    PMCT_CMD_FWR   = 4'h8,
    PMCT_CMD_PC    = 4'h9
  } pmct_cmd_type;

  typedef enum logic [1:0] {
    PMCT_TGT_EXPANSION_RAM_ON  = 2'h0,
    PMCT_TGT_EXPANSION_RAM_OFF = 2'h1,
    PMCT_TGT_FLASH    = 2'h2
  } pmct_target_type;

  typedef struct packed {
    logic [1:0] bytes;
    logic [3:0] clocks;
    logic       cond_br;
    logic       xmove;
    logic       cmove;
  } pmct_timing_type;

  typedef struct packed {
    pmct_target_type target;
    logic [15:0]     addr;
    logic            wr;
    logic [7:0]      data;
  } pmct_xmove_type;

  typedef struct packed {
    pmct_cmd_type cmd;
    logic [15:0]  addr;
    logic [7:0]   data;
  } pmct_dbg_type;

endpackage

// ==== src/pmct_debug_port.sv ====
// serial debug and programming port: synchronised pins, scan register
`timescale 1ns/1ps
module pmct_debug_port
  import pmct_pkg::*;
(
  input  wire logic         i_clk_sys,
  input  wire logic         i_rstn,
  input  wire logic         i_jtag_tck,
  input  wire logic         i_jtag_tms,
  input  wire logic         i_jtag_tdi,
  input  wire logic [7:0]   i_resp,
  output logic              o_jtag_tdo,
  output logic              o_cmd_valid,
  output pmct_dbg_type      o_cmd
);

  // ----------------------------------------------------------------
  // three-stage pin synchronisers, change accepted when the last two stages agree
  // ----------------------------------------------------------------
  logic [2:0] tck_q, tms_q, tdi_q;
  logic       tck_f_q, tms_f_q, tdi_f_q;
  logic       tck_rise;

  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      tck_q   <= 3'h0;
      tms_q   <= 3'h7;
      tdi_q   <= 3'h0;
      tck_f_q <= 1'b0;
      tms_f_q <= 1'b1;
      tdi_f_q <= 1'b0;
    end else begin
      tck_q <= {tck_q[1:0], i_jtag_tck};
      tms_q <= {tms_q[1:0], i_jtag_tms};
      tdi_q <= {tdi_q[1:0], i_jtag_tdi};
      if (tck_q[1] == tck_q[2]) tck_f_q <= tck_q[2];
      if (tms_q[1] == tms_q[2]) tms_f_q <= tms_q[2];
      if (tdi_q[1] == tdi_q[2]) tdi_f_q <= tdi_q[2];
    end
  end

  assign tck_rise = tck_q[1] && tck_q[2] && !tck_f_q;

  // ----------------------------------------------------------------
  // reduced scan controller
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    S_RESET, S_IDLE, S_SELECT, S_CAPTURE, S_SHIFT, S_EXIT, S_UPDATE
  } pmct_scan_type;

  pmct_scan_type                st_q;
  logic [PMCT_DR_BITS-1:0]      dr_q;
  logic [4:0]                   tms_run_q;

  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      st_q      <= S_RESET;
      tms_run_q <= 5'h00;
    end else if (tck_rise) begin
      tms_run_q <= tms_f_q ? tms_run_q + 5'h01 : 5'h00;
      if (tms_f_q && tms_run_q >= PMCT_TLR_TMS - 5'h01) begin
        st_q <= S_RESET;
      end else begin
        case (st_q)
          S_RESET:   st_q <= tms_f_q ? S_RESET : S_IDLE;
          S_IDLE:    st_q <= tms_f_q ? S_SELECT : S_IDLE;
          S_SELECT:  st_q <= tms_f_q ? S_RESET : S_CAPTURE;
          S_CAPTURE: st_q <= tms_f_q ? S_EXIT : S_SHIFT;
          S_SHIFT:   st_q <= tms_f_q ? S_EXIT : S_SHIFT;
          S_EXIT:    st_q <= tms_f_q ? S_UPDATE : S_SHIFT;
          S_UPDATE:  st_q <= tms_f_q ? S_SELECT : S_IDLE;
          default:   st_q <= S_RESET;
        endcase
      end
    end
  end

  // scan register: capture answer, shift lsb first
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      dr_q <= '0;
    end else if (tck_rise && st_q == S_CAPTURE) begin
      dr_q <= {24'h000000, i_resp};
    end else if (tck_rise && st_q == S_SHIFT) begin
      dr_q <= {tdi_f_q, dr_q[PMCT_DR_BITS-1:1]};
    end
  end

  // command pulse once per update, outputs from flops
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      o_cmd_valid <= 1'b0;
      o_cmd       <= '0;
      o_jtag_tdo  <= 1'b0;
    end else begin
      o_cmd_valid <= tck_rise && st_q == S_EXIT && tms_f_q;
      if (tck_rise && st_q == S_EXIT && tms_f_q) begin
        o_cmd.cmd  <= pmct_cmd_type'(dr_q[PMCT_DR_CMD +: 4]);
        o_cmd.addr <= dr_q[PMCT_DR_ADDR +: 16];
        o_cmd.data <= dr_q[PMCT_DR_DATA +: 8];
      end
      o_jtag_tdo <= dr_q[0];
    end
  end

endmodule

// ==== dv/pmct_jtag_host.sv ====
// serial scan host model driving the debug port pins
`timescale 1ns/1ps
module pmct_jtag_host (
  output logic o_tck,
  output logic o_tms,
  output logic o_tdi
);
  initial begin
    o_tck = 1'b0;
    o_tms = 1'b1;
    o_tdi = 1'b0;
  end
  // -------------------------------------------------------------
  // one scan clock, each level held five system clocks
  // -------------------------------------------------------------
  task automatic bit_out(input logic tms, input logic tdi);
    o_tms = tms;
    o_tdi = tdi;
    #500 o_tck = 1'b1;
    #500 o_tck = 1'b0;
  endtask
  // reset, idle, select, capture, shift lsb first, exit, update, idle
  task automatic send(input logic [31:0] w);
    for (int i = 0; i < 5; i++) begin
      bit_out(1'b1, 1'b0);
    end
    bit_out(1'b0, 1'b0);
    bit_out(1'b1, 1'b0);
    bit_out(1'b0, 1'b0);
    bit_out(1'b0, 1'b0);
    for (int i = 0; i < 32; i++) begin
      bit_out(i == 31, w[i]);
    end
    bit_out(1'b1, ~w[31]);
    bit_out(1'b0, w[31]);
    o_tdi = ~o_tdi;
  endtask
endmodule

// ==== dv/pmct_core_timing_bench.sv ====
// self-checking bench for the core timing controller
`timescale 1ns/1ps
module pmct_core_timing_bench
  import pmct_pkg::*;
;
  logic           clk_sys, rstn, op_valid, br_taken, xwr, fl_en, dbg_ack;
  logic [7:0]     opcode, xdata, dbg_rdata, dbg_wdata;
  logic [15:0]    xaddr, fetch_pc, dbg_addr;
  logic           issue, retire, busy, xvalid, cmove_rd, halted;
  logic           dbg_req, dbg_wr, dbg_flash, tdo, tck, tms, tdi;
  pmct_xmove_type xmove, xe, xn;
  logic [3:0]     cq[$];
  pmct_xmove_type xq[$];
  int             cyc, miscompares, tests_run;
  logic [15:0]    rnd;
  logic [15:0]    tbl [10] = '{16'h0811, 16'h0612, 16'h0522, 16'h0123,
    16'h0234, 16'h2215, 16'ha414, 16'h8418, 16'h8313, 16'h9313};

  pmct_core_timing pmct_core_timing_inst (
    .i_clk_sys(clk_sys), .i_rstn(rstn), .i_op_valid(op_valid),
    .i_opcode(opcode), .i_branch_taken(br_taken), .i_pc_load(1'b0),
    .i_pc_target(16'h0000), .i_xmove_addr(xaddr), .i_xmove_wr(xwr),
    .i_xmove_data(xdata), .i_flash_wr_en(fl_en), .i_dbg_rdata(dbg_rdata),
    .i_dbg_ack(dbg_ack), .i_jtag_tck(tck), .i_jtag_tms(tms),
    .i_jtag_tdi(tdi), .o_fetch_pc(fetch_pc), .o_issue(issue),
    .o_retire(retire), .o_busy(busy), .o_xmove_valid(xvalid),
    .o_xmove(xmove), .o_cmove_rd(cmove_rd), .o_halted(halted),
    .o_dbg_req(dbg_req), .o_dbg_wr(dbg_wr), .o_dbg_flash(dbg_flash),
    .o_dbg_addr(dbg_addr), .o_dbg_wdata(dbg_wdata), .o_jtag_tdo(tdo));

  pmct_jtag_host pmct_jtag_host_inst (.o_tck(tck), .o_tms(tms), .o_tdi(tdi));

  // -------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic step();
    @(posedge clk_sys);
    #1;
  endtask

  // offer one opcode, note its clock count, wait until it retires
  task automatic run_op(input logic [7:0] op, input logic tk,
                        input logic [1:0] nb, input logic [3:0] nc);
    logic [15:0] pc0;
    int          n;
    pc0 = fetch_pc;
    opcode = op;
    br_taken = tk;
    op_valid = 1'b1;
    cq.push_back(nc);
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (issue !== 1'b1 && n < 20);
    check("issue", issue, 1'b1);
    step();
    op_valid = 1'b0;
    check("pc step", fetch_pc, pc0 + 16'(nb));
    @(negedge clk_sys);
    if (op == 8'h83 || op == 8'h93) begin
      check("code move", cmove_rd, 1'b1);
    end
    n = 0;
    while (busy !== 1'b0 && n < 20) begin
      step();
      n++;
    end
    check("idle", busy, 1'b0);
  endtask

  task automatic dbg_mem(input logic [31:0] w, input logic [7:0] rd);
    int n;
    pmct_jtag_host_inst.send(w);
    check("tdo", tdo, w[0]);
    n = 0;
    while (dbg_req !== 1'b1 && n < 50) begin
      step();
      n++;
    end
    check("dbg req", dbg_req, 1'b1);
    check("dbg addr", dbg_addr, w[23:8]);
    check("dbg wr", dbg_wr, w[31:28] != 4'h6);
    check("dbg flash", dbg_flash, w[31:28] == 4'h8);
    if (w[31:28] != 4'h6) check("dbg wdata", dbg_wdata, w[7:0]);
    dbg_rdata = rd;
    dbg_ack = 1'b1;
    step();
    dbg_ack = 1'b0;
    step();
    if (w[31:28] == 4'h6) check("dbg rdata", dbg_wdata, rd);
  endtask

  // -------------------------------------------------------------
  // result watcher: oldest note against each retire or move
  // -------------------------------------------------------------
  always @(negedge clk_sys) begin
    cyc++;
    if (retire === 1'b1) begin
      if (cq.size() == 0) check("stray retire", 32'h1, 32'h0);
      else check("clocks", cyc, cq.pop_front());
    end
    if (issue === 1'b1) cyc = 0;
    if (xvalid === 1'b1) begin
      xe = (xq.size() > 0) ? xq.pop_front() : '0;
      check("target", 32'(xmove.target), 32'(xe.target));
      check("xaddr", xmove.addr, xe.addr);
      check("xwr", xmove.wr, xe.wr);
      if (xe.wr) check("xdata", xmove.data, xe.data);
    end
  end

  always #50 clk_sys = ~clk_sys;

  initial begin
    #2_000_000;
    miscompares++;
    conclude();
  end

  // -------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------
  initial begin
    {clk_sys, rstn, op_valid, br_taken, xwr, fl_en, dbg_ack} = '0;
    {opcode, xdata, dbg_rdata, xaddr} = '0;
    cyc = 0;
    rnd = 16'hc805; // seed 51205
    repeat (4) step();
    check("reset pc", fetch_pc, PMCT_RESET_PC);
    rstn = 1'b1;
    foreach (tbl[i]) run_op(tbl[i][15:8], 1'b0, tbl[i][5:4], tbl[i][3:0]);
    for (int i = 0; i < 4; i++) begin
      run_op(i[1] ? 8'h10 : 8'h40, i[0], i[1] ? 2'h3 : 2'h2,
             4'(i[1] ? 3 : 2) + 4'(i[0]));
    end
    for (int i = 0; i < 6; i++) begin
      rnd = lfsr(rnd);
      xwr = i[0];
      fl_en = i[1];
      xaddr = (i == 0) ? 16'h0fff : (i == 1) ? 16'h1000 : rnd;
      xdata = rnd[15:8];
      xn.wr = xwr;
      xn.addr = xaddr;
      xn.data = xdata;
      xn.target = (xwr && fl_en) ? PMCT_TGT_FLASH :
        (xaddr < 16'h1000) ? PMCT_TGT_EXPANSION_RAM_ON : PMCT_TGT_EXPANSION_RAM_OFF;
      xq.push_back(xn);
      run_op({3'h7, xwr, 2'h0, i > 3, 1'b0}, 1'b0, 2'h1, 4'h3);
    end
    opcode = 8'h84;
    op_valid = 1'b1;
    step();
    op_valid = 1'b0;
    repeat (3) step();
    rstn = 1'b0;
    repeat (4) step();
    check("flush pc", fetch_pc, PMCT_RESET_PC);
    check("flush busy", busy, 1'b0);
    rstn = 1'b1;
    pmct_jtag_host_inst.send(32'h1000_0000);
    repeat (8) step();
    check("halted", halted, 1'b1);
    opcode = 8'h08;
    op_valid = 1'b1;
    repeat (10) begin
      @(negedge clk_sys);
      check("refused", issue, 1'b0);
    end
    step();
    op_valid = 1'b0;
    dbg_mem(32'h6000_3400, rnd[7:0]);
    dbg_mem(32'h8001_00a5, 8'h00);
    dbg_mem(32'h7000_4c5a, 8'h00);
    pmct_jtag_host_inst.send(32'h9002_0000);
    pmct_jtag_host_inst.send(32'h4002_0101);
    check("pc load", fetch_pc, 16'h0200);
    pmct_jtag_host_inst.send(32'h2000_0000);
    repeat (8) step();
    check("running", halted, 1'b0);
    run_op(8'h08, 1'b0, 2'h1, 4'h1);
    repeat (4) step();
    check("breakpoint", halted, 1'b1);
    pmct_jtag_host_inst.send(32'h3000_0000);
    run_op(8'h08, 1'b0, 2'h1, 4'h1);
    repeat (2) step();
    check("stepped", halted, 1'b1);
    check("ram size", PMCT_IRAM_BYTES, 32'd256);
    check("sfr size", PMCT_SFR_BYTES, 32'd128);
    check("pending", cq.size() + xq.size(), 32'h0);
    conclude();
  end
endmodule
